/* hw/eifst_map.vh */
// Constants for the external request flag skip test block
`ifndef EIFST_MAP_VH
`define EIFST_MAP_VH

// Instruction word layout
`define EIFST_INSTR_W        10
`define EIFST_OP_SKIP_EXT0   10'h038
`define EIFST_OP_SKIP_EXT1   10'h039

// Request channels
`define EIFST_NCH            2
`define EIFST_CH_EXT0        0
`define EIFST_CH_EXT1        1

// Enable bits inside first_interrupt_control_reg
`define EIFST_EN0_BIT        0
`define EIFST_EN1_BIT        1
`define EIFST_CTRL_W         2
`define EIFST_CTRL_RST       2'h0

// APB register byte offsets
`define EIFST_ADDR_W         8
`define EIFST_OFS_CTRL       8'h00
`define EIFST_OFS_FLAG       8'h04
`define EIFST_OFS_STAT       8'h08
`define EIFST_OFS_CNT        8'h0C

// Status register fields
`define EIFST_STAT_SKIP_BIT  0
`define EIFST_STAT_NOP_BIT   1
`define EIFST_STAT_CH_BIT    2
`define EIFST_STAT_RST       3'h0

// Skip counters, one byte per channel
`define EIFST_CNT_W          8
`define EIFST_CNT_RST        8'h00
`define EIFST_CNT_ONE        8'h01

`define EIFST_DATA_W         32
`define EIFST_DATA_RST       32'h0000_0000

`endif

/* hw/eifst_dec.v */
// Opcode decode and skip decision for the two request flag tests
`include "eifst_map.vh"

module eifst_dec (
  input  wire                      i_instr_valid,
  input  wire [`EIFST_INSTR_W-1:0] i_instr,
  input  wire [`EIFST_CTRL_W-1:0]  i_enable_bits,
  input  wire [`EIFST_NCH-1:0]     i_request_flags,
  output wire [`EIFST_NCH-1:0]     o_hit,
  output wire [`EIFST_NCH-1:0]     o_skip,
  output wire [`EIFST_NCH-1:0]     o_nop
);

  // Opcode match, one word, one cycle
  assign o_hit[`EIFST_CH_EXT0] = i_instr_valid & (i_instr == `EIFST_OP_SKIP_EXT0);
  assign o_hit[`EIFST_CH_EXT1] = i_instr_valid & (i_instr == `EIFST_OP_SKIP_EXT1);

  // Enable bit set turns the test into a no-operation
  assign o_nop[`EIFST_CH_EXT0] = o_hit[`EIFST_CH_EXT0] & i_enable_bits[`EIFST_EN0_BIT];
  assign o_nop[`EIFST_CH_EXT1] = o_hit[`EIFST_CH_EXT1] & i_enable_bits[`EIFST_EN1_BIT];

  // Skip only with enable clear and flag at one; flag zero falls through
  assign o_skip[`EIFST_CH_EXT0] = o_hit[`EIFST_CH_EXT0] & ~i_enable_bits[`EIFST_EN0_BIT]
                                  & i_request_flags[`EIFST_CH_EXT0];
  assign o_skip[`EIFST_CH_EXT1] = o_hit[`EIFST_CH_EXT1] & ~i_enable_bits[`EIFST_EN1_BIT]
                                  & i_request_flags[`EIFST_CH_EXT1];

endmodule

/* hw/eifst_core.v */
// External request flag skip test: execute logic, flags and APB registers
//
// What this block does
// - Decode external-0 flag test opcode, one cycle
// - Enable clear, flag one: skip next
// - Skip on external-0 clears its flag
// - Flag zero: next instruction runs normally
// - Enable bit 0 set: test is no-operation
// - Decode external-1 flag test opcode, one cycle
// - Enable clear, flag one: skip next
// - Skip on external-1 clears its flag
// - Flag zero: next instruction runs normally
// - Enable bit 1 set: test is no-operation
`include "eifst_map.vh"

module eifst_core (
  input  wire                      i_core_clk,
  input  wire                      i_nrst,
  // Instruction execute port
  input  wire                      i_instr_valid,
  input  wire [`EIFST_INSTR_W-1:0] i_instr,
  output wire                      o_skip_next,
  output wire                      o_test_done,
  // Request flag set pulses from edge detection
  input  wire                      i_ext0_set,
  input  wire                      i_ext1_set,
  output wire                      o_ext0_request_flag,
  output wire                      o_ext1_request_flag,
  output wire                      o_ext0_enable_bit,
  output wire                      o_ext1_enable_bit,
  // APB slave
  input  wire                      i_psel,
  input  wire                      i_penable,
  input  wire                      i_pwrite,
  input  wire [`EIFST_ADDR_W-1:0]  i_paddr,
  input  wire [`EIFST_DATA_W-1:0]  i_pwdata,
  output wire [`EIFST_DATA_W-1:0]  o_prdata,
  output wire                      o_pready,
  output wire                      o_pslverr
);

  // Register address decode, shared by read and write paths
  function addr_known;
    input [`EIFST_ADDR_W-1:0] addr;
    begin
      addr_known = (addr == `EIFST_OFS_CTRL) || (addr == `EIFST_OFS_FLAG) ||
                   (addr == `EIFST_OFS_STAT) || (addr == `EIFST_OFS_CNT);
    end
  endfunction

  // State
  reg  [`EIFST_CTRL_W-1:0]  ctrl_r;
  reg  [`EIFST_CTRL_W-1:0]  ctrl_nxt;
  reg  [`EIFST_NCH-1:0]     flag_r;
  reg  [`EIFST_NCH-1:0]     flag_nxt;
  reg  [2:0]                stat_r;
  reg  [2:0]                stat_nxt;
  reg                       skip_r;
  reg                       done_r;
  reg                       pready_r;
  reg                       pready_nxt;
  reg                       pslverr_r;
  reg                       pslverr_nxt;
  reg  [`EIFST_DATA_W-1:0]  prdata_r;
  reg  [`EIFST_DATA_W-1:0]  prdata_nxt;
  reg  [`EIFST_DATA_W-1:0]  rd_mux;
  reg  [`EIFST_CNT_W-1:0]   cnt_r [0:`EIFST_NCH-1];

  wire [`EIFST_NCH-1:0]     hit;
  wire [`EIFST_NCH-1:0]     skip;
  wire [`EIFST_NCH-1:0]     nop;
  wire [`EIFST_NCH-1:0]     set_in;
  wire [`EIFST_NCH-1:0]     sw_clr;
  wire                      acc_phase;
  wire                      wr_fire;
  wire                      rd_fire;
  wire                      addr_ok;

  assign set_in[`EIFST_CH_EXT0] = i_ext0_set;
  assign set_in[`EIFST_CH_EXT1] = i_ext1_set;

  // Decode and skip decision
  eifst_dec u_dec (
    .i_instr_valid   (i_instr_valid),
    .i_instr         (i_instr),
    .i_enable_bits   (ctrl_r),
    .i_request_flags (flag_r),
    .o_hit           (hit),
    .o_skip          (skip),
    .o_nop           (nop)
  );

  // APB phase tracking; one wait state keeps all answers registered
  assign acc_phase = i_psel & i_penable;
  assign addr_ok   = addr_known(i_paddr);
  assign wr_fire   = acc_phase & pready_r & i_pwrite & addr_ok;
  assign rd_fire   = acc_phase & ~pready_r & ~i_pwrite;

  // Software clear of flags: write one to the flag register bit
  assign sw_clr = (wr_fire && (i_paddr == `EIFST_OFS_FLAG)) ?
                  i_pwdata[`EIFST_NCH-1:0] : {`EIFST_NCH{1'b0}};

  // Control register next value
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_fire && (i_paddr == `EIFST_OFS_CTRL)) begin
      ctrl_nxt = i_pwdata[`EIFST_CTRL_W-1:0];
    end
  end

  // Flag next value; a set in the clearing cycle wins so no request is lost
  genvar ch;
  generate
    for (ch = 0; ch < `EIFST_NCH; ch = ch + 1) begin : g_flag
      always @* begin
        flag_nxt[ch] = flag_r[ch];
        if (skip[ch] || sw_clr[ch]) begin
          flag_nxt[ch] = 1'b0;
        end
        if (set_in[ch]) begin
          flag_nxt[ch] = 1'b1;
        end
      end

      // Skip counter per channel, wraps; cleared by any write to its register
      always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          cnt_r[ch] <= `EIFST_CNT_RST;
        end else if (wr_fire && (i_paddr == `EIFST_OFS_CNT)) begin
          cnt_r[ch] <= `EIFST_CNT_RST;
        end else if (skip[ch]) begin
          cnt_r[ch] <= cnt_r[ch] + `EIFST_CNT_ONE;
        end
      end
    end
  endgenerate

  // Outcome of the last executed test: skipped, no-op, channel
  always @* begin
    stat_nxt = stat_r;
    if (|hit) begin
      stat_nxt[`EIFST_STAT_SKIP_BIT] = |skip;
      stat_nxt[`EIFST_STAT_NOP_BIT]  = |nop;
      stat_nxt[`EIFST_STAT_CH_BIT]   = hit[`EIFST_CH_EXT1];
    end
  end

  // Read data mux; reserved bits read as zero
  always @* begin
    rd_mux = `EIFST_DATA_RST;
    case (i_paddr)
      `EIFST_OFS_CTRL: begin
        rd_mux[`EIFST_CTRL_W-1:0] = ctrl_r;
      end
      `EIFST_OFS_FLAG: begin
        rd_mux[`EIFST_NCH-1:0] = flag_r;
      end
      `EIFST_OFS_STAT: begin
        rd_mux[2:0] = stat_r;
      end
      `EIFST_OFS_CNT: begin
        rd_mux[`EIFST_CNT_W-1:0]                = cnt_r[`EIFST_CH_EXT0];
        rd_mux[2*`EIFST_CNT_W-1:`EIFST_CNT_W] = cnt_r[`EIFST_CH_EXT1];
      end
      default: begin
        rd_mux = `EIFST_DATA_RST;
      end
    endcase
  end

  // APB answer: ready one cycle after access phase starts, then drops
  always @* begin
    pready_nxt  = acc_phase & ~pready_r;
    pslverr_nxt = acc_phase & ~pready_r & ~addr_ok;
    prdata_nxt  = prdata_r;
    if (rd_fire) begin
      prdata_nxt = addr_ok ? rd_mux : `EIFST_DATA_RST;
    end
  end

  // Register bank and execute outputs
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r    <= `EIFST_CTRL_RST;
      flag_r    <= {`EIFST_NCH{1'b0}};
      stat_r    <= `EIFST_STAT_RST;
      skip_r    <= 1'b0;
      done_r    <= 1'b0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `EIFST_DATA_RST;
    end else begin
      ctrl_r    <= ctrl_nxt;
      flag_r    <= flag_nxt;
      stat_r    <= stat_nxt;
      skip_r    <= |skip;
      done_r    <= |hit;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // Every output comes straight from a flop
  assign o_skip_next         = skip_r;
  assign o_test_done         = done_r;
  assign o_ext0_request_flag = flag_r[`EIFST_CH_EXT0];
  assign o_ext1_request_flag = flag_r[`EIFST_CH_EXT1];
  assign o_ext0_enable_bit   = ctrl_r[`EIFST_EN0_BIT];
  assign o_ext1_enable_bit   = ctrl_r[`EIFST_EN1_BIT];
  assign o_prdata            = prdata_r;
  assign o_pready            = pready_r;
  assign o_pslverr           = pslverr_r;

endmodule

/* verification/eifst_core_asserts.sv */
// Port assertions for the request flag skip test block
`include "eifst_map.vh"
module eifst_chk (
  input wire                      i_core_clk,
  input wire                      i_nrst,
  input wire                      i_instr_valid,
  input wire [`EIFST_INSTR_W-1:0] i_instr,
  input wire                      i_ext0_set,
  input wire                      i_ext1_set,
  input wire                      o_skip_next,
  input wire                      o_test_done,
  input wire                      o_ext0_request_flag,
  input wire                      o_ext1_request_flag,
  input wire                      o_ext0_enable_bit,
  input wire                      o_ext1_enable_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // Opcode strobes; a set pulse in the test cycle would win, so it is excluded
  wire t0 = i_instr_valid && (i_instr == `EIFST_OP_SKIP_EXT0);
  wire t1 = i_instr_valid && (i_instr == `EIFST_OP_SKIP_EXT1);
  wire tt = t0 || t1;
  wire k0 = t0 && !o_ext0_enable_bit && o_ext0_request_flag && !i_ext0_set;
  wire k1 = t1 && !o_ext1_enable_bit && o_ext1_request_flag && !i_ext1_set;
  sequence s_skip; o_skip_next && o_test_done; endsequence
  sequence s_pass; !o_skip_next && o_test_done; endsequence
  a_skip_ext0: assert property (k0 |=> s_skip ##0 !o_ext0_request_flag) else $error("ext0 skip");
  a_skip_ext1: assert property (k1 |=> s_skip ##0 !o_ext1_request_flag) else $error("ext1 skip");
  a_pass_ext0: assert property (t0 && !o_ext0_request_flag |=> s_pass) else $error("ext0 pass");
  a_pass_ext1: assert property (t1 && !o_ext1_request_flag |=> s_pass) else $error("ext1 pass");
  a_nop_ext0: assert property (t0 && o_ext0_enable_bit && !i_ext0_set |=> s_pass ##0 $stable(o_ext0_request_flag))
    else $error("ext0 nop");
  a_nop_ext1: assert property (t1 && o_ext1_enable_bit && !i_ext1_set |=> s_pass ##0 $stable(o_ext1_request_flag))
    else $error("ext1 nop");
  a_done_cause: assert property (o_test_done |-> $past(tt)) else $error("stray done");
  a_flag_source: assert property ($rose(o_ext0_request_flag) |-> $past(i_ext0_set)) else $error("flag rose");
  a_flag_source1: assert property ($rose(o_ext1_request_flag) |-> $past(i_ext1_set)) else $error("flag1 rose");
endmodule

bind eifst_core eifst_chk u_chk (.i_core_clk, .i_nrst, .i_instr_valid, .i_instr, .i_ext0_set, .i_ext1_set,
  .o_skip_next, .o_test_done, .o_ext0_request_flag, .o_ext1_request_flag, .o_ext0_enable_bit, .o_ext1_enable_bit);

/* verification/eifst_core_test.sv */
// Self-checking bench for the request flag skip test block
`include "eifst_map.vh"
module eifst_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, nrst = 0, iv = 0, s0 = 0, s1 = 0, psel = 0, pen = 0, pw = 0, er, ch, en, fl;
  logic [9:0]  op = 10'h000;
  logic [7:0]  pa = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  wire  [31:0] prd;
  wire         skp, dn, f0, f1, e0, e1, rdy, serr;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  logic        q[$];
  eifst_core uut (.i_core_clk(clk), .i_nrst(nrst), .i_instr_valid(iv), .i_instr(op), .o_skip_next(skp),
    .o_test_done(dn), .i_ext0_set(s0), .i_ext1_set(s1), .o_ext0_request_flag(f0), .o_ext1_request_flag(f1),
    .o_ext0_enable_bit(e0), .o_ext1_enable_bit(e1), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
    .i_paddr(pa), .i_pwdata(wd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr));
  always #4 clk = ~clk;
  task check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer; an extra edge after release keeps psel from being driven twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pw <= w;
    pa <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    er = serr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  // Valid stays up so tests can follow back to back
  task ins(input logic [9:0] o, input logic t, x);
    iv <= 1;
    op <= o;
    if (t) q.push_back(x);
    @(posedge clk);
  endtask
  task pulse(input logic a, b);
    s0 <= a;
    s1 <= b;
    @(posedge clk);
    s0 <= 0;
    s1 <= 0;
  endtask
  // Each done pulse retires the oldest expected skip; also the hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      results;
    end
    if (dn === 1'b1) begin
      if (q.size() == 0) check("stray done", 1, 0);
      else check("skip", skp, q.pop_front());
    end
  end
  initial begin
    rd = $urandom(32'hC0EC);
    repeat (10) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    check("reset flags", {f1, f0}, 0);
    // Every channel, enable and flag combination
    for (int c = 0; c < 8; c++) begin
      {fl, en, ch} = c[2:0];
      apb(1, `EIFST_OFS_CTRL, 32'(en) << ch);
      check("enable", {e1, e0}, 32'(en) << ch);
      pulse(fl & ~ch, fl & ch);
      ins(ch ? `EIFST_OP_SKIP_EXT1 : `EIFST_OP_SKIP_EXT0, 1, fl & ~en);
      iv <= 0;
      repeat (2) @(posedge clk);
      check("flag", {f1, f0}, 32'(fl & en) << ch);
      apb(0, `EIFST_OFS_FLAG, 0);
      check("flag reg", rd, 32'(fl & en) << ch);
      apb(1, `EIFST_OFS_FLAG, 32'h3);
    end
    // Back-to-back tests on both channels
    apb(1, `EIFST_OFS_CTRL, 0);
    pulse(1, 1);
    ins(`EIFST_OP_SKIP_EXT0, 1, 1);
    ins(`EIFST_OP_SKIP_EXT1, 1, 1);
    iv <= 0;
    repeat (2) @(posedge clk);
    check("flags cleared", {f1, f0}, 0);
    // One skip per channel in the sweep and one each back to back
    apb(0, `EIFST_OFS_CNT, 0);
    check("skip count", rd, 32'h0000_0202);
    // Last test was a channel 1 skip
    apb(0, `EIFST_OFS_STAT, 0);
    check("status", rd, 32'h0000_0005);
    // Random other opcodes must leave set flags alone
    pulse(1, 1);
    for (int i = 0; i < 16; i++) begin
      rd = $urandom;
      ins(rd[9:1] == 9'h01C ? rd[9:0] ^ 10'h200 : rd[9:0], 0, 0);
    end
    iv <= 0;
    repeat (2) @(posedge clk);
    check("flags kept", {f1, f0}, 3);
    apb(0, 8'h10, 0);
    check("pslverr", er, 1);
    check("pending", q.size(), 0);
    results;
  end
endmodule
